/* File: hdl/hpc_counter64.sv */
// One 64-bit counter with half-word write access.
// Assumes write strobes are already checked for privilege by the parent.
`timescale 1ns/1ps
module hpc_counter64 #(
    parameter int NRW   = 32,
    parameter int INC_W = 2
) (
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      rst_n,
    // Counting
    input  wire logic                      inc_en,
    input  wire logic [INC_W-1:0]          inc_amt,
    // Software writes
    input  wire logic                      wr_lo,
    input  wire logic                      wr_hi,
    input  wire logic [NRW-1:0]            wdata,
    // Current value
    output logic      [hpc_pkg::CNT_W-1:0] value
);

    typedef struct packed {
        logic [hpc_pkg::CNT_W-1:0] cnt;
    } hpc_cnt_s;

    hpc_cnt_s state_reg;
    hpc_cnt_s state_next;
    logic [hpc_pkg::CNT_W-1:0] wd_ext;

    always_comb begin
        state_next = state_reg;
        wd_ext     = hpc_pkg::CNT_W'(wdata);
        // A write drops the increment of its own cycle, so the value stays as written.
        if (wr_lo || wr_hi) begin
            if (wr_lo) begin
                state_next.cnt[NRW-1:0] = wd_ext[NRW-1:0];
            end
            if (wr_hi) begin
                state_next.cnt[hpc_pkg::CNT_W-1:hpc_pkg::HALF_W] = wd_ext[hpc_pkg::HALF_W-1:0];
            end
        end else if (inc_en) begin
            state_next.cnt = state_reg.cnt + hpc_pkg::CNT_W'(inc_amt);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg.cnt <= hpc_pkg::CNT_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign value = state_reg.cnt;

endmodule : hpc_counter64

/* File: hdl/hpc_csr_top.sv */
// Machine performance counters of one hart: cycle, retired instructions,
// event counters, their selectors, the lower-mode access gate and the
// increment stop register, with read-only user views.
// Assumes the pipeline presents one CSR access per request pulse, at the
// point where the accessing instruction commits, and reads the answer
// one cycle later.
//
// Operation
// - Cycle counter adds one each core clock unless its stop bit is set.
// - Retired counter adds the retire count each cycle unless stopped.
// - Cycle and retired counters are 64 bits for either register width.
// - Counters need no defined reset value; software may write any value.
// - A counter write lands after its instruction, overriding its own increment.
// - One shared cycle counter copy, so every sharing hart sees writes; here each hart's block keeps its own.
// - Twenty-nine 64-bit event counters, slots 3 to 31, each with selector.
// - Selector picks the event; code zero means no event, no counting.
// - An event counter and selector may be read-only zero, ignoring writes.
// - Narrow width: low registers hold bits 31-0, high registers bits 63-32.
// - Access gate: bit0 cycle, bit1 timer, bit2 retired, bit n event n.
// - Touching the access gate never changes nor stops any counter.
// - Clear gate bit makes lower-mode view read an illegal instruction.
// - Set gate bit permits the view in the next lower implemented mode.
// - User views mirror machine counters; timer view mirrors external timer.
// - Narrow width: timer and other views split into low and high halves.
// - Gate register exists with user mode; omitted without user mode.
// - Clear stop bit lets the counter count; set stop bit halts it.
// - Stop map: cycle bit 0, retired bit 2, events 3-31, bit 1 zero.
// - Stop bits never change lower-mode accessibility.
// - The cycle stop bit is shared with the shared cycle counter; here no counter is shared.
// - Without the stop register every counter always counts.
`timescale 1ns/1ps
module hpc_csr_top #(
    parameter int              NRW         = 32,
    parameter int              RET_W       = 2,
    parameter int              NUM_EVENTS  = 16,
    parameter int              EVSEL_W     = 8,
    parameter logic [31:0]     EV_IMPL     = hpc_pkg::EV_IMPL_DEF,
    parameter bit              HAS_S       = 1'b1,
    parameter bit              HAS_U       = 1'b1,
    parameter bit              HAS_INHIBIT = 1'b1
) (
    // Clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         rst_n,
    // CSR access request
    input  wire logic                         csr_req,
    input  wire logic                         csr_we,
    input  wire logic [hpc_pkg::ADDR_W-1:0]   csr_addr,
    input  wire logic [NRW-1:0]               csr_wdata,
    input  wire logic [1:0]                   priv_mode,
    // CSR access answer
    output logic                              rsp_valid,
    output logic      [NRW-1:0]               rsp_rdata,
    output logic                              rsp_illegal,
    // Pipeline strobes
    input  wire logic [RET_W-1:0]             retire_cnt,
    input  wire logic [NUM_EVENTS-1:0]        event_in,
    // External real-time timer
    input  wire logic [hpc_pkg::CNT_W-1:0]    wall_time
);

    // ********************************************************************
    // State
    // ********************************************************************

    typedef struct packed {
        logic                      rsp_valid;
        logic                      rsp_illegal;
        logic [NRW-1:0]            rdata;
        logic [hpc_pkg::HALF_W-1:0] enable;
        logic [hpc_pkg::HALF_W-1:0] inhibit;
    } hpc_state_s;

    hpc_state_s state_reg;
    hpc_state_s state_next;

    // ********************************************************************
    // Decode
    // ********************************************************************

    localparam bit NARROW = (NRW == hpc_pkg::HALF_W);

    logic [hpc_pkg::GRP_W-1:0]  grp;
    logic [hpc_pkg::IDX_W-1:0]  idx;
    logic                       is_mlo;
    logic                       is_mhi;
    logic                       is_slo;
    logic                       is_shi;
    logic                       is_ulo;
    logic                       is_uhi;
    logic                       is_en;
    logic                       is_inh;
    logic                       is_hi;
    logic                       m_mode;
    logic                       low_mode;
    logic                       illegal;
    logic                       do_wr;
    hpc_pkg::hpc_priv_e         lower_mode;

    assign grp = csr_addr[hpc_pkg::ADDR_W-1:hpc_pkg::IDX_W];
    assign idx = csr_addr[hpc_pkg::IDX_W-1:0];

    // High halves exist only at the narrow register width.
    assign is_mlo = (grp == hpc_pkg::GRP_MCNT_LO);
    assign is_mhi = (grp == hpc_pkg::GRP_MCNT_HI) && NARROW;
    assign is_slo = (grp == hpc_pkg::GRP_SEL_LO);
    assign is_shi = (grp == hpc_pkg::GRP_SEL_HI) && NARROW;
    assign is_ulo = (grp == hpc_pkg::GRP_UCNT_LO);
    assign is_uhi = (grp == hpc_pkg::GRP_UCNT_HI) && NARROW;
    assign is_en  = (grp == hpc_pkg::GRP_CTRL) && (idx == hpc_pkg::IDX_ENABLE);
    assign is_inh = (grp == hpc_pkg::GRP_CTRL) && (idx == hpc_pkg::IDX_INHIBIT);
    assign is_hi  = is_mhi || is_shi || is_uhi;

    assign m_mode     = (priv_mode == hpc_pkg::HPC_PRIV_M);
    assign lower_mode = HAS_S ? hpc_pkg::HPC_PRIV_S : hpc_pkg::HPC_PRIV_U;
    assign low_mode   = (priv_mode == lower_mode);

    // ********************************************************************
    // Counter array
    // ********************************************************************

    logic [hpc_pkg::CNT_W-1:0]   ctr_val [hpc_pkg::NUM_CTR];
    logic [EVSEL_W-1:0]          sel_val [hpc_pkg::NUM_CTR];
    logic [hpc_pkg::HALF_W-1:0]  cnt_lo_we;
    logic [hpc_pkg::HALF_W-1:0]  cnt_hi_we;
    logic [hpc_pkg::HALF_W-1:0]  sel_lo_we;
    logic [hpc_pkg::HALF_W-1:0]  inh_eff;
    logic [hpc_pkg::HALF_W-1:0]  ctr_impl;

    assign ctr_impl = hpc_pkg::FIXED_SLOTS | (EV_IMPL & ~hpc_pkg::FIXED_SLOTS);

    // The timer slot can never be stopped, and an absent stop register acts
    // as all zero while any access to it is refused as illegal.
    assign inh_eff = HAS_INHIBIT ? (state_reg.inhibit & ~hpc_pkg::INHIBIT_RO0 & ctr_impl)
                                 : '0;

    // One counter instance per implemented slot other than the timer, private to this block's hart: no copy is
    // shared with another hart, so a write is seen by this hart alone.
    generate
        for (genvar i = 0; i < hpc_pkg::NUM_CTR; i++) begin : g_slot
            if (i == hpc_pkg::SLOT_TM) begin : g_time
                assign ctr_val[i] = wall_time;
                assign sel_val[i] = '0;
            end else if (i < hpc_pkg::SLOT_EV_FIRST) begin : g_fixed
                logic [RET_W-1:0] amt;
                assign amt = (i == hpc_pkg::SLOT_CY) ? RET_W'(1) : retire_cnt;
                hpc_counter64 #(
                    .NRW    (NRW),
                    .INC_W  (RET_W)
                ) u_cnt (
                    .sys_clk (sys_clk),
                    .rst_n   (rst_n),
                    .inc_en  (!inh_eff[i]),
                    .inc_amt (amt),
                    .wr_lo   (cnt_lo_we[i]),
                    .wr_hi   (cnt_hi_we[i]),
                    .wdata   (csr_wdata),
                    .value   (ctr_val[i])
                );
                assign sel_val[i] = '0;
            end else if (EV_IMPL[i]) begin : g_event
                logic fire;
                hpc_evsel #(
                    .NRW        (NRW),
                    .EVSEL_W    (EVSEL_W),
                    .NUM_EVENTS (NUM_EVENTS)
                ) u_sel (
                    .sys_clk   (sys_clk),
                    .rst_n     (rst_n),
                    .wr_lo     (sel_lo_we[i]),
                    .wdata     (csr_wdata),
                    .event_in  (event_in),
                    .sel_value (sel_val[i]),
                    .fire      (fire)
                );
                hpc_counter64 #(
                    .NRW    (NRW),
                    .INC_W  (1)
                ) u_cnt (
                    .sys_clk (sys_clk),
                    .rst_n   (rst_n),
                    .inc_en  (fire && !inh_eff[i]),
                    .inc_amt (1'b1),
                    .wr_lo   (cnt_lo_we[i]),
                    .wr_hi   (cnt_hi_we[i]),
                    .wdata   (csr_wdata),
                    .value   (ctr_val[i])
                );
            end else begin : g_absent
                // Absent slots read zero and drop writes.
                assign ctr_val[i] = '0;
                assign sel_val[i] = '0;
            end
        end
    endgenerate

    // ********************************************************************
    // Access check
    // ********************************************************************

    always_comb begin
        illegal = 1'b1;
        if (is_mlo || is_mhi) begin
            // The timer slot has no machine counter behind it.
            illegal = !m_mode || (idx == hpc_pkg::IDX_W'(hpc_pkg::SLOT_TM));
        end else if (is_slo || is_shi) begin
            illegal = !m_mode || (idx < hpc_pkg::IDX_W'(hpc_pkg::SLOT_EV_FIRST));
        end else if (is_en) begin
            illegal = !m_mode || !HAS_U;
        end else if (is_inh) begin
            illegal = !m_mode || !HAS_INHIBIT;
        end else if (is_ulo || is_uhi) begin
            // Views are read-only. The stop register is never consulted
            // here, so stopping a counter leaves its view reachable.
            if (csr_we) begin
                illegal = 1'b1;
            end else if (m_mode) begin
                illegal = 1'b0;
            end else begin
                illegal = !(low_mode && HAS_U && state_reg.enable[idx]);
            end
        end
    end

    assign do_wr = csr_req && csr_we && !illegal;

    always_comb begin
        cnt_lo_we = '0;
        cnt_hi_we = '0;
        sel_lo_we = '0;
        // Selector high halves hold no bits here, so their writes are dropped.
        if (do_wr && (is_mlo || is_mhi || is_slo) && ctr_impl[idx]) begin
            cnt_lo_we[idx] = is_mlo;
            cnt_hi_we[idx] = is_mhi;
            sel_lo_we[idx] = is_slo;
        end
    end

    // ********************************************************************
    // Read path
    // ********************************************************************

    logic [hpc_pkg::CNT_W-1:0] rd64;
    logic [NRW-1:0]            rd_word;

    always_comb begin
        rd64 = '0;
        if (is_mlo || is_mhi || is_ulo || is_uhi) begin
            rd64 = ctr_val[idx];
        end else if (is_slo || is_shi) begin
            rd64 = hpc_pkg::CNT_W'(sel_val[idx]);
        end else if (is_en) begin
            rd64 = hpc_pkg::CNT_W'(state_reg.enable);
        end else if (is_inh) begin
            rd64 = hpc_pkg::CNT_W'(inh_eff);
        end
        if (is_hi) begin
            rd_word = NRW'(rd64 >> hpc_pkg::HALF_W);
        end else begin
            rd_word = NRW'(rd64);
        end
    end

    // ********************************************************************
    // Next state
    // ********************************************************************

    always_comb begin
        state_next             = state_reg;
        state_next.rsp_valid   = csr_req;
        state_next.rsp_illegal = csr_req && illegal;
        // Reads return the value before a write in the same access.
        if (csr_req) begin
            state_next.rdata = illegal ? '0 : rd_word;
        end
        // The gate register only stores; stop bits halt their counters through inh_eff.
        if (do_wr && is_en) begin
            state_next.enable = csr_wdata[hpc_pkg::HALF_W-1:0] & ctr_impl;
        end
        if (do_wr && is_inh) begin
            state_next.inhibit = csr_wdata[hpc_pkg::HALF_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg.rsp_valid   <= 1'b0;
            state_reg.rsp_illegal <= 1'b0;
            state_reg.rdata       <= '0;
            state_reg.enable      <= hpc_pkg::ENABLE_RST;
            state_reg.inhibit     <= hpc_pkg::INHIBIT_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************

    assign rsp_valid   = state_reg.rsp_valid;
    assign rsp_illegal = state_reg.rsp_illegal;
    assign rsp_rdata   = state_reg.rdata;

endmodule : hpc_csr_top

/* File: hdl/hpc_evsel.sv */
// Event selector for one event counter and the event picked by it.
// Assumes event strobes are one-cycle pulses synchronous to sys_clk.
`timescale 1ns/1ps
module hpc_evsel #(
    parameter int NRW        = 32,
    parameter int EVSEL_W    = 8,
    parameter int NUM_EVENTS = 16
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // Software write of the low half
    input  wire logic                  wr_lo,
    input  wire logic [NRW-1:0]        wdata,
    // Platform events
    input  wire logic [NUM_EVENTS-1:0] event_in,
    // Selector value and selected event
    output logic      [EVSEL_W-1:0]    sel_value,
    output logic                       fire
);

    typedef struct packed {
        logic [EVSEL_W-1:0] sel;
    } hpc_sel_s;

    hpc_sel_s state_reg;
    hpc_sel_s state_next;

    always_comb begin
        state_next = state_reg;
        // Codes beyond the event list are not legal and are held as zero.
        if (wr_lo) begin
            if (wdata > NRW'(NUM_EVENTS)) begin
                state_next.sel = '0;
            end else begin
                state_next.sel = wdata[EVSEL_W-1:0];
            end
        end
    end

    always_comb begin
        fire = 1'b0;
        // Code zero matches no event, so the counter never moves.
        for (int i = 0; i < NUM_EVENTS; i++) begin
            if (state_reg.sel == EVSEL_W'(i + 1)) begin
                fire = event_in[i];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg.sel <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sel_value = state_reg.sel;

endmodule : hpc_evsel

/* File: hdl/hpc_pkg.sv */
// Shared constants for the hart performance counter block.
// Assumes a single core clock and a CSR access port driven by the hart pipeline.
package hpc_pkg;

    // ********************************************************************
    // Widths
    // ********************************************************************
    localparam int CNT_W      = 64;
    localparam int HALF_W     = 32;
    localparam int NUM_CTR    = 32;
    localparam int ADDR_W     = 12;
    localparam int IDX_W      = 5;
    localparam int GRP_W      = ADDR_W - IDX_W;

    // ********************************************************************
    // Counter slots within the 32-bit enable and inhibit maps
    // ********************************************************************
    localparam int SLOT_CY       = 0;
    localparam int SLOT_TM       = 1;
    localparam int SLOT_IR       = 2;
    localparam int SLOT_EV_FIRST = 3;

    // ********************************************************************
    // Register index groups; the low five address bits pick the slot
    // ********************************************************************
    localparam logic [GRP_W-1:0] GRP_MCNT_LO = 7'h08;
    localparam logic [GRP_W-1:0] GRP_MCNT_HI = 7'h0C;
    localparam logic [GRP_W-1:0] GRP_SEL_LO  = 7'h10;
    localparam logic [GRP_W-1:0] GRP_SEL_HI  = 7'h14;
    localparam logic [GRP_W-1:0] GRP_UCNT_LO = 7'h18;
    localparam logic [GRP_W-1:0] GRP_UCNT_HI = 7'h1C;
    localparam logic [GRP_W-1:0] GRP_CTRL    = 7'h20;
    localparam logic [IDX_W-1:0] IDX_ENABLE  = 5'h00;
    localparam logic [IDX_W-1:0] IDX_INHIBIT = 5'h01;

    // ********************************************************************
    // Reset values and fixed fields
    // ********************************************************************
    localparam logic [HALF_W-1:0] ENABLE_RST     = 32'h0000_0000;
    localparam logic [HALF_W-1:0] INHIBIT_RST    = 32'h0000_0000;
    localparam logic [HALF_W-1:0] INHIBIT_RO0    = 32'h0000_0002;
    localparam logic [HALF_W-1:0] FIXED_SLOTS    = 32'h0000_0007;
    localparam logic [CNT_W-1:0]  CNT_RST        = 64'h0000_0000_0000_0000;
    localparam logic [HALF_W-1:0] EV_IMPL_DEF    = 32'hFFFF_FFF8;

    // ********************************************************************
    // Privilege modes
    // ********************************************************************
    typedef enum logic [1:0] {
        HPC_PRIV_U = 2'b00,
        HPC_PRIV_S = 2'b01,
        HPC_PRIV_M = 2'b11
    } hpc_priv_e;

endpackage : hpc_pkg

/* File: verif/hpc_csr_top_bench.sv */
// Self-checking bench of the hart performance counter block.
// Assumes slot 3 is built absent and the far model feeds strobes and timer.
`timescale 1ns/1ps
module hpc_csr_top_bench;
    logic        sys_clk   = 1'b0;
    logic        rst_n     = 1'b0;
    logic        csr_req   = 1'b0;
    logic        csr_we    = 1'b0;
    logic [11:0] csr_addr  = 12'h000;
    logic [31:0] csr_wdata = 32'h0;
    logic [1:0]  priv_mode = 2'b11;
    logic        run       = 1'b0;
    logic        rsp_valid;
    logic        rsp_illegal;
    logic [31:0] rsp_rdata;
    logic [1:0]  retire_cnt;
    logic [15:0] event_in;
    logic [63:0] wall_time;
    logic [31:0] rd;
    logic [31:0] r0;
    logic        ill;
    logic [11:0] slot [4] = '{12'h100, 12'h102, 12'h104, 12'h105};
    logic [31:0] dlt  [4] = '{32'h2, 32'h2, 32'h1, 32'h0};
    int          error_cnt = 0;
    int          checked   = 0;
    always #4 sys_clk = ~sys_clk;
    hpc_csr_top #(.EV_IMPL(32'hFFFF_FFF0)) hpc_csr_top_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .csr_req(csr_req), .csr_we(csr_we), .csr_addr(csr_addr),
        .csr_wdata(csr_wdata), .priv_mode(priv_mode), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_illegal(rsp_illegal), .retire_cnt(retire_cnt), .event_in(event_in), .wall_time(wall_time));
    hpc_far_model hpc_far_model_inst (
        .sys_clk(sys_clk), .run(run), .retire_cnt(retire_cnt), .event_in(event_in), .wall_time(wall_time));
    // ****************************************************************
    // Access tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic we, input logic [11:0] a, input logic [31:0] d, input logic [1:0] m);
        @(posedge sys_clk);
        #1;
        csr_req   = 1'b1;
        csr_we    = we;
        csr_addr  = a;
        csr_wdata = d;
        priv_mode = m;
        @(posedge sys_clk);
        #1;
        csr_req = 1'b0;
        rd      = rsp_rdata;
        ill     = rsp_illegal;
        chk({31'h0, rsp_valid}, 32'h1);
    endtask : acc
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (10) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        acc(1'b0, 12'h400, 32'h0, 2'b11);
        chk(rd, 32'h0);
        acc(1'b1, 12'h100, 32'h0000_0010, 2'b11);
        acc(1'b0, 12'h100, 32'h0, 2'b11);
        chk(rd, 32'h0000_0011);
        acc(1'b1, 12'h180, 32'h0000_00AB, 2'b11);
        acc(1'b0, 12'h180, 32'h0, 2'b11);
        chk(rd, 32'h0000_00AB);
        $display("Test write and halves done");
        acc(1'b1, 12'h401, 32'hFFFF_FFFF, 2'b11);
        acc(1'b0, 12'h401, 32'h0, 2'b11);
        chk(rd, 32'hFFFF_FFF5);
        acc(1'b0, 12'h100, 32'h0, 2'b11);
        r0 = rd;
        acc(1'b0, 12'h300, 32'h0, 2'b01);
        chk({31'h0, ill}, 32'h1);
        acc(1'b1, 12'h400, 32'h0000_0011, 2'b11);
        acc(1'b0, 12'h400, 32'h0, 2'b11);
        chk(rd, 32'h0000_0011);
        acc(1'b0, 12'h300, 32'h0, 2'b01);
        chk({31'h0, ill}, 32'h0);
        chk(rd, r0);
        acc(1'b0, 12'h300, 32'h0, 2'b00);
        chk({31'h0, ill}, 32'h1);
        acc(1'b1, 12'h300, 32'h0, 2'b11);
        chk({31'h0, ill}, 32'h1);
        acc(1'b0, 12'h100, 32'h0, 2'b01);
        chk({31'h0, ill}, 32'h1);
        acc(1'b0, 12'h301, 32'h0, 2'b11);
        chk(rd, wall_time[31:0]);
        acc(1'b0, 12'h381, 32'h0, 2'b11);
        chk(rd, wall_time[63:32]);
        $display("Test stop and gate done");
        acc(1'b1, 12'h103, 32'h0000_5555, 2'b11);
        acc(1'b0, 12'h103, 32'h0, 2'b11);
        chk(rd, 32'h0);
        acc(1'b1, 12'h204, 32'h1, 2'b11);
        acc(1'b1, 12'h205, 32'h0, 2'b11);
        acc(1'b1, 12'h401, 32'h0, 2'b11);
        run = 1'b1;
        foreach (slot[i]) begin
            acc(1'b0, slot[i], 32'h0, 2'b11);
            r0 = rd;
            acc(1'b0, slot[i], 32'h0, 2'b11);
            chk(rd - r0, dlt[i]);
        end
        $display("Test counting done");
        wrap_up();
    end
    initial begin
        #20000;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end
endmodule : hpc_csr_top_bench

/* File: verif/hpc_csr_top_checker.sv */
// Port-level checks of the hart performance counter block.
// Assumes the default parameters of hpc_csr_top, supervisor mode present.
`timescale 1ns/1ps
module hpc_csr_top_checker #(
    parameter int NRW        = 32,
    parameter int RET_W      = 2,
    parameter int NUM_EVENTS = 16
) (
    // Clock and reset
    input wire logic                  sys_clk,
    input wire logic                  rst_n,
    // CSR access
    input wire logic                  csr_req,
    input wire logic                  csr_we,
    input wire logic [11:0]           csr_addr,
    input wire logic [NRW-1:0]        csr_wdata,
    input wire logic [1:0]            priv_mode,
    input wire logic                  rsp_valid,
    input wire logic [NRW-1:0]        rsp_rdata,
    input wire logic                  rsp_illegal,
    // Strobes and timer
    input wire logic [RET_W-1:0]      retire_cnt,
    input wire logic [NUM_EVENTS-1:0] event_in,
    input wire logic [63:0]           wall_time
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    logic [31:0] tm_lo;
    logic [31:0] tm_hi;
    logic        m_rd;
    assign tm_lo = wall_time[31:0];
    assign tm_hi = wall_time[63:32];
    assign m_rd  = csr_req && !csr_we && priv_mode == 2'b11;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_RSP_NEXT: assert property (csr_req |=> rsp_valid)
        else $error("No answer after a request");
    AST_RSP_ONLY: assert property (!csr_req |=> !rsp_valid && !rsp_illegal)
        else $error("Answer without a request");
    AST_ILL_ZERO: assert property (rsp_illegal |-> rsp_valid && rsp_rdata == '0)
        else $error("Refused access returned data");
    AST_USER_VIEW: assert property (csr_req && priv_mode == 2'b00 && csr_addr[11:8] == 4'h3 |=> rsp_illegal)
        else $error("User view read was allowed");
    AST_VIEW_WR: assert property (csr_req && csr_we && csr_addr[11:8] == 4'h3 |=> rsp_illegal)
        else $error("View write was accepted");
    AST_MACH_LOW: assert property (csr_req && priv_mode != 2'b11 && csr_addr[11:8] inside {4'h1, 4'h2}
        |=> rsp_illegal)
        else $error("Machine register reached from a lower mode");
    AST_TM_LO: assert property (m_rd && csr_addr == 12'h301 |=> rsp_rdata[31:0] == $past(tm_lo))
        else $error("Low timer view differs from timer");
    AST_TM_HI: assert property (m_rd && csr_addr == 12'h381 |=> rsp_rdata[31:0] == $past(tm_hi))
        else $error("High timer view differs from timer");
    AST_STOP_BIT1: assert property (m_rd && csr_addr == 12'h401 |=> !rsp_rdata[1])
        else $error("Timer stop bit reads one");
    cover property (csr_req && priv_mode != 2'b11 ##1 rsp_illegal);
    cover property (m_rd && csr_addr == 12'h301);
    cover property (csr_req && csr_we ##1 rsp_valid && !rsp_illegal);
endmodule : hpc_csr_top_checker

bind hpc_csr_top hpc_csr_top_checker #(.NRW(NRW), .RET_W(RET_W), .NUM_EVENTS(NUM_EVENTS)) hpc_csr_top_checker_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .csr_req(csr_req), .csr_we(csr_we), .csr_addr(csr_addr),
    .csr_wdata(csr_wdata), .priv_mode(priv_mode), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_illegal(rsp_illegal), .retire_cnt(retire_cnt), .event_in(event_in), .wall_time(wall_time));

/* File: verif/hpc_far_model.sv */
// Retire and event strobes and the external wall timer.
// Assumes the bench raises run only while it wants counting traffic.
`timescale 1ns/1ps
module hpc_far_model (
    // Clock and control
    input  wire logic        sys_clk,
    input  wire logic        run,
    // Strobes and timer
    output logic      [1:0]  retire_cnt,
    output logic      [15:0] event_in,
    output logic      [63:0] wall_time
);
    // The start value sits across the half boundary so both views differ.
    logic [63:0] time_reg = 64'h0000_0001_8000_0000;
    logic        tgl_reg  = 1'b0;
    always_ff @(posedge sys_clk) begin
        time_reg <= run ? time_reg + 64'h1 : time_reg;
        tgl_reg  <= ~tgl_reg;
    end
    assign wall_time  = time_reg;
    assign retire_cnt = run ? 2'h1 : 2'h0;
    assign event_in   = run ? {15'h0, tgl_reg} : 16'h0;
endmodule : hpc_far_model
